// ===== src/l2_cache_pkg.sv
// constants for the second-level cache sram and tag interface
// assumes a single 40 MHz host clock domain
package l2_cache_pkg;
  localparam int TAG_W       = 8;    // base tag bits
  localparam int TAG_EXT_W   = 3;    // extension tag bits
  localparam int LINE_QWORDS = 4;    // quadwords per cache line
  localparam int BE_W        = 8;    // host byte enables
  localparam int QCNT_W      = 2;    // quadword counter width
  localparam int CFG_W       = 2;    // cache_config width
  localparam int CFG_EXT_BIT = 0;    // extended_tag_enable position
  localparam int CFG_DRC_BIT = 1;    // dram cache enable position
  localparam logic [QCNT_W-1:0] QCNT_RST = 2'h0;
  localparam logic [QCNT_W-1:0] QCNT_LAST = 2'h3;
  localparam logic [TAG_EXT_W-1:0] EXT_ZERO = 3'h0;
  localparam logic [BE_W-1:0] BE_NONE = 8'hff;
  localparam logic [QCNT_W-1:0] QCNT_STEP = 2'h1;  // one quadword
  localparam logic STROBE_OFF = 1'h1;  // idle level of low strobes
  localparam logic FLAG_OFF   = 1'h0;  // cleared flag or released pin

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,  // waiting for a request
    ST_LOOKUP = 3'b001,  // tag read and compare
    ST_READ   = 3'b010,  // burst read to processor
    ST_WRITE  = 3'b011,  // processor write hit
    ST_FILL   = 3'b100,  // line fill, tag write
    ST_INVAL  = 3'b101   // inquire invalidate, tag write
  } l2_state_t;
endpackage : l2_cache_pkg

// ===== src/l2_tag_compare.sv
// tag compare: matches the tag bus against the upper address bits
// assumes tag bits masked by the caller when the extension is off
`timescale 1ns/1ps
`default_nettype none
module l2_tag_compare
  import l2_cache_pkg::*;
#(
  parameter int W = TAG_W + TAG_EXT_W
) (
  input  wire logic [W-1:0] tagIn,    // tag read from tag ram
  input  wire logic [W-1:0] addrTag,  // expected tag from address
  input  wire logic         valid,    // line status valid bit
  output logic              hit       // match with valid status
);
  // per-bit equality, reduced below
  logic [W-1:0] bitEq;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_eq
      assign bitEq[i] = (tagIn[i] == addrTag[i]);
    end
  endgenerate
  assign hit = valid & (&bitEq);
endmodule // l2_tag_compare
`default_nettype wire

// ===== src/l2_cache_sram_tag_interface.sv
// second-level cache control: burst sram strobes and external tag bus
// assumes synchronous inputs on sys_clk, one request at a time
// Functional notes
// - asserting burst advance steps the data rams to the next quadword.
// - asserting the address strobe loads the sram address register.
// - chip select at the address strobe powers the cache up, else down.
// - output enable is asserted only while cache data goes to the bus.
// - global write writes every byte lane regardless of byte enables.
// - partial writes hold global write high and drive byte write low.
// - tag bus is input on processor access, output on fill and invalidate.
// - upper tag bits count only when the extended tag enable is set.
// - with the extension off the upper tag bits are held low internally.
// - extended tag and dram cache are never active together; here both bits set keep the extension on and raise cfgConflict.
// - tag write strobe stores the presented tag and state in the tag ram.
`timescale 1ns/1ps
`default_nettype none
module l2_cache_sram_tag_interface
  import l2_cache_pkg::*;
#(
  parameter int LINE_Q = LINE_QWORDS
) (
  input  wire logic                 sys_clk,           // host clock
  input  wire logic                 sys_rst,           // sync reset
  input  wire logic                 accReq,            // processor access
  input  wire logic                 accWrite,          // access is write
  input  wire logic                 accPartial,        // partial write
  input  wire logic                 accBurst,          // burst access
  input  wire logic                 fillReq,           // line fill request
  input  wire logic                 invalReq,          // inquire invalidate
  input  wire logic                 cacheEnable,       // cache present
  input  wire logic [CFG_W-1:0]     cache_config,      // config bits
  input  wire logic [TAG_W-1:0]     addrTag,           // address tag
  input  wire logic [TAG_EXT_W-1:0] addrTagExt,        // address ext tag
  input  wire logic                 lineValid,         // status valid
  input  wire logic [TAG_W-1:0]     tagBusIn,          // tag_bus pins in
  input  wire logic [TAG_EXT_W-1:0] tagBusExtIn,       // tag_bus_ext in
  output logic [TAG_W-1:0]          tagBusOut,         // tag_bus out
  output logic                      tagBusOe,          // tag_bus enable
  output logic [TAG_EXT_W-1:0]      tagBusExtOut,      // tag_bus_ext out
  output logic                      tagBusExtOe,       // ext enable
  output logic                      tag_write_n,       // tag write
  output logic                      sram_addr_strobe_n,   // sram ads
  output logic                      burst_advance_n,      // advance
  output logic                      sram_chip_select_n,   // chip sel
  output logic                      sram_output_enable_n, // oe
  output logic                      global_write_n,       // all lanes
  output logic                      byte_write_n,         // lane write
  output logic                      cacheHit,          // hit result
  output logic                      accDone,           // access finished
  output logic                      cfgConflict        // bad config seen
);
  // the quadword counter must wrap exactly at the end of a line
  if (LINE_Q != LINE_QWORDS) begin : g_bad_line
    $error("line length must equal the quadword counter range");
  end
  if ((1 << QCNT_W) != LINE_Q) begin : g_bad_qcnt
    $error("quadword counter width does not match the line length");
  end

  l2_state_t stateQ, stateD;
  logic [QCNT_W-1:0] qcntQ, qcntD;
  logic hitQ;
  logic [TAG_W-1:0] tagOutQ;
  logic [TAG_EXT_W-1:0] tagExtOutQ;
  logic tagOeQ, tagExtOeQ, twenQ, adsnQ, advnQ, csnQ, oenQ, gwnQ, bwnQ;
  logic doneQ, conflictQ;

  // configuration decode, extension wins over dram cache
  wire extReq    = cache_config[CFG_EXT_BIT];
  wire dramReq   = cache_config[CFG_DRC_BIT];
  wire extOn     = extReq;
  wire conflict  = extReq & dramReq;

  // upper tag bits forced low when the extension is off
  wire [TAG_EXT_W-1:0] extIn  = extOn ? tagBusExtIn : EXT_ZERO;
  wire [TAG_EXT_W-1:0] extAdr = extOn ? addrTagExt : EXT_ZERO;

  // tag compare on the sampled tag bus
  logic cmpHit;
  l2_tag_compare #(.W(TAG_W + TAG_EXT_W)) u_cmp (
    .tagIn   ({extIn, tagBusIn}),
    .addrTag ({extAdr, addrTag}),
    .valid   (lineValid),
    .hit     (cmpHit)
  );

  // state and quadword decode
  wire lastQ     = (qcntQ == QCNT_LAST);
  wire inIdle    = (stateQ == ST_IDLE);
  wire startAcc  = inIdle & cacheEnable & accReq;
  wire startFill = inIdle & cacheEnable & fillReq & ~accReq;
  wire startInv  = inIdle & cacheEnable & invalReq & ~accReq & ~fillReq;

  // next state
  always_comb begin
    stateD = stateQ;
    qcntD  = qcntQ;
    unique case (stateQ)
      ST_IDLE: begin
        qcntD = QCNT_RST;
        if (startAcc)
          stateD = ST_LOOKUP;
        else if (startFill)
          stateD = ST_FILL;
        else if (startInv)
          stateD = ST_INVAL;
      end
      ST_LOOKUP: begin
        if (!cmpHit)
          stateD = ST_IDLE;
        else if (accWrite)
          stateD = ST_WRITE;
        else
          stateD = ST_READ;
      end
      ST_READ, ST_WRITE, ST_FILL: begin
        qcntD = qcntQ + QCNT_STEP;
        if (lastQ || (!accBurst && stateQ != ST_FILL))
          stateD = ST_IDLE;
      end
      ST_INVAL: stateD = ST_IDLE;
      default:  stateD = ST_IDLE;
    endcase
  end

  // output decode, all active low strobes
  wire inRead  = (stateD == ST_READ);
  wire inWrite = (stateD == ST_WRITE);
  wire inFill  = (stateD == ST_FILL);
  wire inInv   = (stateD == ST_INVAL);
  wire ramData = inRead | inWrite | inFill;
  wire firstQ  = (stateQ == ST_LOOKUP) | (inIdle & inFill);
  // chip select asserted on access start, even if the lookup then misses, and on every data cycle
  wire csnD    = ~((inIdle & startAcc) | ramData);
  // address strobe on access start and on fill start
  wire adsnD   = ~((inIdle & startAcc) | (inIdle & inFill));
  // advance on each later quadword of the line
  wire advnD   = ~(ramData & ~firstQ);
  wire oenD    = ~inRead;
  wire fullWr  = (inWrite & ~accPartial) | inFill;
  wire gwnD    = ~fullWr;
  wire bwnD    = ~(inWrite & accPartial);
  wire drive   = inFill | inInv;
  wire twenD   = ~(drive & (firstQ | inInv));

  // state register
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      stateQ <= ST_IDLE;
    else
      stateQ <= stateD;
  end

  // quadword counter within the line
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      qcntQ <= QCNT_RST;
    else
      qcntQ <= qcntD;
  end

  // sram address strobe
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      adsnQ <= STROBE_OFF;
    else
      adsnQ <= adsnD;
  end

  // burst advance, later quadwords only
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      advnQ <= STROBE_OFF;
    else
      advnQ <= advnD;
  end

  // sram chip select
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      csnQ <= STROBE_OFF;
    else
      csnQ <= csnD;
  end

  // sram output enable, read data cycles only
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      oenQ <= STROBE_OFF;
    else
      oenQ <= oenD;
  end

  // global write, all lanes
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      gwnQ <= STROBE_OFF;
    else
      gwnQ <= gwnD;
  end

  // byte write, lanes chosen by the host byte enables
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      bwnQ <= STROBE_OFF;
    else
      bwnQ <= bwnD;
  end

  // tag bus output enable on fill and invalidate
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      tagOeQ <= FLAG_OFF;
    else
      tagOeQ <= drive;
  end

  // extension output enable, only with the extension on
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      tagExtOeQ <= FLAG_OFF;
    else
      tagExtOeQ <= drive & extOn;
  end

  // new tag on fill, zero tag on invalidate
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      tagOutQ <= '0;
    else
      tagOutQ <= inFill ? addrTag : '0;
  end

  // extension tag, held low while the extension is off
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      tagExtOutQ <= EXT_ZERO;
    else
      tagExtOutQ <= inFill ? extAdr : EXT_ZERO;
  end

  // tag write strobe
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      twenQ <= STROBE_OFF;
    else
      twenQ <= twenD;
  end

  // hit result of the last lookup
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      hitQ <= FLAG_OFF;
    else
      hitQ <= (stateQ == ST_LOOKUP) ? cmpHit : hitQ;
  end

  // one-cycle done pulse on return to idle
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      doneQ <= FLAG_OFF;
    else
      doneQ <= ~inIdle & (stateD == ST_IDLE);
  end

  // both configuration functions requested
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      conflictQ <= FLAG_OFF;
    else
      conflictQ <= conflict;
  end

  assign tagBusOut            = tagOutQ;
  assign tagBusOe             = tagOeQ;
  assign tagBusExtOut         = tagExtOutQ;
  assign tagBusExtOe          = tagExtOeQ;
  assign tag_write_n          = twenQ;
  assign sram_addr_strobe_n   = adsnQ;
  assign burst_advance_n      = advnQ;
  assign sram_chip_select_n   = csnQ;
  assign sram_output_enable_n = oenQ;
  assign global_write_n       = gwnQ;
  assign byte_write_n         = bwnQ;
  assign cacheHit             = hitQ;
  assign accDone              = doneQ;
  assign cfgConflict          = conflictQ;
endmodule // l2_cache_sram_tag_interface
`default_nettype wire

// ===== tb/l2_cache_props.sv
// checker: strobe and tag bus relations of the cache interface
// assumes a bind to the top module, seeing its ports only
`timescale 1ns/1ps
`default_nettype none
module l2_cache_props
  import l2_cache_pkg::*;
(
  input wire logic             sys_clk,              // host clock
  input wire logic             sys_rst,              // sync reset
  input wire logic [CFG_W-1:0] cache_config,         // config bits
  input wire logic             tagBusOe,             // tag drive
  input wire logic             tagBusExtOe,          // ext tag drive
  input wire logic             tag_write_n,          // tag write
  input wire logic             sram_addr_strobe_n,   // address strobe
  input wire logic             burst_advance_n,      // advance
  input wire logic             sram_chip_select_n,   // chip select
  input wire logic             sram_output_enable_n, // output enable
  input wire logic             global_write_n,       // all lanes
  input wire logic             byte_write_n,         // lane write
  input wire logic             cfgConflict           // conflict flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // strobe, tag bus and configuration relations
  reset_idle_a: assert property (disable iff (1'b0)
    sys_rst |=> sram_output_enable_n && tag_write_n && !tagBusOe)
    else $error("active after reset");
  ads_select_a: assert property (
    !sram_addr_strobe_n |-> !sram_chip_select_n) else $error("ads no cs");
  oe_read_a: assert property (
    !sram_output_enable_n |-> global_write_n && byte_write_n && !tagBusOe)
    else $error("oe misuse");
  lane_write_a: assert property (
    !byte_write_n |-> global_write_n) else $error("bw with gw");
  advance_data_a: assert property (
    !burst_advance_n |-> !(sram_output_enable_n && global_write_n
    && byte_write_n)) else $error("advance idle");
  tag_store_a: assert property (
    !tag_write_n |-> tagBusOe) else $error("tag write undriven");
  ext_off_a: assert property (
    tagBusExtOe |-> $past(cache_config[CFG_EXT_BIT])) else $error("ext drv");
  cfg_conflict_a: assert property (
    (&cache_config) [*2] |-> cfgConflict) else $error("no conflict");
endmodule // l2_cache_props
bind l2_cache_sram_tag_interface l2_cache_props u_props (.sys_clk, .sys_rst,
  .cache_config, .tagBusOe, .tagBusExtOe, .tag_write_n, .sram_addr_strobe_n,
  .burst_advance_n, .sram_chip_select_n, .sram_output_enable_n,
  .global_write_n, .byte_write_n, .cfgConflict);
`default_nettype wire

// ===== tb/l2_tag_ram_model.sv
// partner: external tag ram with the pull resistors of the tag pins
// assumes the design drives the pins only while its enables are high
`timescale 1ns/1ps
`default_nettype none
module l2_tag_ram_model
  import l2_cache_pkg::*;
(
  input wire logic sys_clk, // host clock
  input wire logic extOn, // extension on
  input wire logic csN, // chip select
  input wire logic twN, // tag write
  input wire logic [TAG_W-1:0] tOut, // design tag
  input wire logic tOe, // design drives
  input wire logic [TAG_EXT_W-1:0] xOut, // design ext tag
  input wire logic xOe, // design drives ext
  output logic [TAG_W-1:0] tIn, // resolved pins
  output logic [TAG_EXT_W-1:0] xIn // resolved ext pins
);
  logic [TAG_W-1:0] memT;
  logic [TAG_EXT_W-1:0] memX;
  logic rd;
  // store presented tag on the write strobe
  always @(posedge sys_clk) if (!twN) begin
    memT <= tOut;
    memX <= xOe ? xOut : memX;
  end
  // drive only while selected, else pull levels (top ext bit up if off)
  assign rd = !csN && !tOe;
  assign tIn = tOe ? tOut : rd ? memT : '0;
  assign xIn = xOe ? xOut : (rd && extOn) ? memX : {!extOn, 2'b00};
endmodule // l2_tag_ram_model
`default_nettype wire

// ===== tb/l2_cache_sram_tag_interface_tb.sv
// testbench: fills, invalidates and accesses under each configuration
// assumes the tag ram model beside the design and the bound checker
`timescale 1ns/1ps
`default_nettype none
module l2_cache_sram_tag_interface_tb;
  import l2_cache_pkg::*;
  typedef struct {logic hit; int nData; int nByte; int nAdv;} note_t;
  logic sys_clk = 0, sys_rst = 1, accReq = 0, accWrite = 0, accPartial = 0;
  logic accBurst = 0, fillReq = 0, invalReq = 0, lineValid = 1, busy = 0;
  logic cacheEnable = 1, tagBusOe, tagBusExtOe, tag_write_n, cacheHit;
  logic sram_addr_strobe_n, burst_advance_n, sram_chip_select_n, accDone;
  logic sram_output_enable_n, global_write_n, byte_write_n, cfgConflict;
  logic [CFG_W-1:0] cache_config = '0;
  logic [TAG_W-1:0] addrTag = '0, tagBusIn, tagBusOut, expT;
  logic [TAG_EXT_W-1:0] addrTagExt = '0, tagBusExtIn, tagBusExtOut, expX;
  int n_errors = 0, n_tests = 0, nS = 0, nB = 0, nA = 0, nC = 0;
  note_t notes[$], e;
  always #12.5 sys_clk = !sys_clk;
  l2_cache_sram_tag_interface uut (.sys_clk, .sys_rst, .accReq, .accWrite,
    .accPartial, .accBurst, .fillReq, .invalReq, .cacheEnable, .cache_config,
    .addrTag, .addrTagExt, .lineValid, .tagBusIn, .tagBusExtIn, .tagBusOut,
    .tagBusOe, .tagBusExtOut, .tagBusExtOe, .tag_write_n, .sram_addr_strobe_n,
    .burst_advance_n, .sram_chip_select_n, .sram_output_enable_n,
    .global_write_n, .byte_write_n, .cacheHit, .accDone, .cfgConflict);
  l2_tag_ram_model ram (.sys_clk, .extOn(cache_config[CFG_EXT_BIT]),
    .csN(sram_chip_select_n), .twN(tag_write_n), .tOut(tagBusOut),
    .tOe(tagBusOe), .xOut(tagBusExtOut), .xOe(tagBusExtOe), .tIn(tagBusIn),
    .xIn(tagBusExtIn));
  task automatic chkBit(logic got, logic exp, string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic chkCnt(int got, int exp, string what);
    chkBit(got == exp, 1'b1, what);
  endtask
  task automatic end_sim;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // processor access: note the expected outcome, request, await done
  task automatic access(logic w, p, b, v, logic [TAG_W-1:0] t,
                        logic [TAG_EXT_W-1:0] x);
    logic h;
    int n;
    h = v && t == expT && (!cache_config[CFG_EXT_BIT] || x == expX);
    n = h ? (b ? LINE_QWORDS : 1) : 0;
    notes.push_back('{h, n, (w && p) ? n : 0, (n > 1) ? n - 1 : 0});
    @(posedge sys_clk);
    {accWrite, accPartial, accBurst, lineValid} <= {w, p, b, v};
    {addrTag, addrTagExt, accReq, busy} <= {t, x, 2'b11};
    @(posedge sys_clk);
    accReq <= 0;
    repeat (20) begin
      @(posedge sys_clk);
      if (accDone === 1'b1) break;
    end
    busy <= 0;
  endtask
  // line fill or invalidate, fixed length from the hand-over walk
  task automatic lineOp(logic f, logic [TAG_W-1:0] t, logic [TAG_EXT_W-1:0] x);
    @(posedge sys_clk);
    {fillReq, invalReq, addrTag, addrTagExt} <= {f, !f, t, x};
    @(posedge sys_clk);
    {fillReq, invalReq} <= 2'b00;
    repeat (8) @(posedge sys_clk);
    expT = f ? t : '0;
    expX = f ? x : '0;
  endtask
  // compare each finished access with the oldest note
  always @(posedge sys_clk) if (busy) begin
    nS += int'(sram_output_enable_n !== 1'b1 || global_write_n !== 1'b1
               || byte_write_n !== 1'b1);
    nB += int'(byte_write_n !== 1'b1);
    nA += int'(burst_advance_n !== 1'b1);
    nC += int'(sram_addr_strobe_n !== 1'b1);
    if (accDone === 1'b1 && notes.size() > 0) begin
      e = notes.pop_front();
      chkBit(cacheHit, e.hit, "hit");
      chkCnt(nS, e.nData, "data cycles");
      chkCnt(nB, e.nByte, "byte lanes");
      chkCnt(nA, e.nAdv, "advance cycles");
      chkCnt(nC, 1, "address strobes");
      nS = 0;
      nB = 0;
      nA = 0;
      nC = 0;
    end
  end
  // watchdog, several times the expected run
  initial begin
    repeat (4000) @(posedge sys_clk);
    n_errors++;
    end_sim;
  end
  initial begin
    logic [TAG_W-1:0] t;
    logic [TAG_EXT_W-1:0] x;
    void'($urandom(80575));
    repeat (4) @(posedge sys_clk);
    sys_rst <= 0;
    for (int c = 0; c < 4; c++) begin
      t = 8'($urandom % 255 + 1);
      x = 3'($urandom);
      cache_config <= c[1:0];
      lineOp(1, t, x);
      chkBit(cfgConflict, c == 3, "conflict");
      access(0, 0, 1, 1, t, x);
      access(1, 1, 0, 1, t, x);
      access(1, 0, 1, 1, t, x);
      access(0, 0, 0, 1, t, x ^ 3'h4);
      access(0, 0, 1, 0, t, x);
      lineOp(0, t, x);
      access(0, 0, 1, 1, t, x);
    end
    // cache disabled: requests leave the sram deselected
    cacheEnable <= 0;
    accReq <= 1;
    repeat (4) begin
      @(posedge sys_clk);
      chkBit(sram_chip_select_n & sram_addr_strobe_n, 1'b1, "off");
    end
    accReq <= 0;
    chkCnt(notes.size(), 0, "accesses left open");
    end_sim;
  end
endmodule // l2_cache_sram_tag_interface_tb
`default_nettype wire
